// >>> proto_support_regs.sv
// protocol support registers: parameters, checksums, smart card control
//
// The implementer's own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
module proto_support_regs (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rx_pin,
  input wire logic etu_tick,
  input wire logic tx_byte_valid,
  input wire logic [7:0] tx_byte,
  input wire logic tx_is_pid,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_is_pid,
  input wire logic break_detected,
  input wire logic tx_char_ok,
  input wire logic tx_line_err,
  input wire logic rx_char_ok,
  input wire logic rx_parity_err,
  input wire logic [8:0] guard_load_value,
  input wire logic guard_start,
  input wire logic block_start,
  input wire logic wait_start,
  output logic retransmit_req,
  output logic logic_convention_sel,
  output logic card_protocol_sel,
  output logic error_line_o,
  output logic error_line_oe_n,
  output logic card_irq,
  output logic event_irq
);
  import uart_proto_pkg::*;
  typedef struct packed {
    logic [8:0] param_two_field;
    logic [15:0] param_three_field;
    logic [7:0] param_three_high;
    logic [1:0] retransmit_count;
    logic logic_convention_sel;
    logic error_pulldown_length;
    logic card_protocol_sel;
    logic rx_repeat_flag;
    logic tx_repeat_flag;
    logic block_time_flag;
    logic wait_time_flag;
    logic guard_time_flag;
    logic rx_repeat_irq_en;
    logic tx_repeat_irq_en;
    logic block_time_irq_en;
    logic wait_time_irq_en;
    logic guard_time_irq_en;
    logic wakeup_flag;
    logic autobaud_done_flag;
    logic autobaud_done_irq_en;
    logic [2:0] mode;
    logic checksum_include_ctrl;
    logic wake_en;
    logic autobaud_enable;
    logic [8:0] guard_cnt;
    logic guard_run;
    logic [8:0] block_cnt;
    logic block_run;
    logic [23:0] wait_cnt;
    logic wait_run;
    logic [2:0] tx_errs;
    logic [2:0] rx_errs;
    logic [1:0] pulldown_cnt;
    logic [2:0] autobaud_falls;
    logic rx_s1;
    logic rx_s2;
    logic rx_prev;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic bus_ready;
    logic retransmit;
    logic card_irq;
    logic event_irq;
    logic line_oe_n;
    logic resp;
    logic line_o;
  } state_s;
  state_s q;
  state_s d;
  sum_if tx_sum ();
  sum_if rx_sum ();
  // =====================================================================
  // helpers
  function automatic logic hit(input logic pend, input logic [7:0] addr,
                               input logic [7:0] off);
    hit = pend && (addr == off);
  endfunction
  // returns {reached_zero, next_count}
  function automatic logic [24:0] tick_down(input logic [23:0] cnt, input logic tick);
    tick_down = !tick ? {1'b0, cnt} :
                (cnt <= 24'h000001) ? {1'b1, 24'h000000} : {1'b0, cnt - 24'h000001};
  endfunction
  function automatic logic [31:0] read_word(input state_s s, input logic [7:0] addr,
                                            input logic [7:0] txs, input logic [7:0] rxs);
    unique case (addr)
      OFF_PARAM_TWO: read_word = {23'h000000, s.param_two_field};
      OFF_PARAM_THREE: read_word = {16'h0000, s.param_three_field};
      OFF_PARAM_THREE_HIGH: read_word = {24'h000000, s.param_three_high};
      OFF_TX_CHECKSUM: read_word = {24'h000000, txs};
      OFF_RX_CHECKSUM: read_word = {24'h000000, rxs};
      OFF_SMARTCARD_CONFIG: read_word = {26'h0000000, s.retransmit_count,
        s.logic_convention_sel, s.error_pulldown_length, s.card_protocol_sel, 1'b0};
      OFF_SMARTCARD_IRQ: read_word = {18'h00000, s.rx_repeat_flag, s.tx_repeat_flag,
        1'b0, s.block_time_flag, s.wait_time_flag, s.guard_time_flag, 2'h0,
        s.rx_repeat_irq_en, s.tx_repeat_irq_en, 1'b0, s.block_time_irq_en,
        s.wait_time_irq_en, s.guard_time_irq_en};
      OFF_WAKE_AUTOBAUD_IRQ: read_word = {24'h000000, s.wakeup_flag,
        s.autobaud_done_flag, 3'h0, s.autobaud_done_irq_en, 2'h0};
      OFF_PROTOCOL_CONTROL: read_word = {25'h0000000, s.autobaud_enable, s.wake_en,
        s.checksum_include_ctrl, 1'b0, s.mode};
      default: read_word = RESET_WORD;
    endcase
  endfunction
  // =====================================================================
  // decode and checksum feeds
  logic accept;
  logic lin_mode;
  logic lin_slave_mode;
  logic card_mode;
  logic falling;
  logic [15:0] w;
  logic [24:0] guard_r;
  logic [24:0] block_r;
  logic [24:0] wait_r;
  assign accept = hsel && htrans[1] && hready;
  assign w = hwdata[15:0];
  assign lin_mode = (q.mode == MODE_LIN_MASTER) || (q.mode == MODE_LIN_SLAVE) ||
                    (q.mode == MODE_LIN_MASTER_SLAVE);
  assign lin_slave_mode = (q.mode == MODE_LIN_SLAVE) || (q.mode == MODE_LIN_MASTER_SLAVE);
  assign card_mode = (q.mode == MODE_SMARTCARD);
  assign falling = q.rx_prev && !q.rx_s2;
  assign tx_sum.add_byte = tx_byte;
  assign tx_sum.add_valid = tx_byte_valid && (lin_mode ?
    (!tx_is_pid || q.checksum_include_ctrl) : q.checksum_include_ctrl);
  assign tx_sum.clear = break_detected && lin_slave_mode;
  assign tx_sum.load = hit(q.wr_pend, q.wr_addr, OFF_TX_CHECKSUM);
  assign tx_sum.load_value = hwdata[7:0];
  assign rx_sum.add_byte = rx_byte;
  assign rx_sum.add_valid = rx_byte_valid && (lin_mode ?
    (!rx_is_pid || q.checksum_include_ctrl) : q.checksum_include_ctrl);
  assign rx_sum.clear = break_detected && lin_slave_mode;
  assign rx_sum.load = hit(q.wr_pend, q.wr_addr, OFF_RX_CHECKSUM);
  assign rx_sum.load_value = hwdata[7:0];
  checksum_acc tx_acc (
    .hclk(hclk),
    .hresetn(hresetn),
    .port(tx_sum.acc)
  );
  checksum_acc rx_acc (
    .hclk(hclk),
    .hresetn(hresetn),
    .port(rx_sum.acc)
  );
  // time counters step on the ETU tick, only in smart card mode
  assign guard_r = tick_down({15'h0000, q.guard_cnt}, etu_tick && q.guard_run);
  assign block_r = tick_down({15'h0000, q.block_cnt}, etu_tick && q.block_run);
  assign wait_r = tick_down(q.wait_cnt, etu_tick && q.wait_run);
  // =====================================================================
  // next state
  always_comb begin
    d = q;
    d.retransmit = 1'b0;
    d.bus_ready = 1'b1;
    // receive line synchroniser and edge history
    d.rx_s1 = rx_pin;
    d.rx_s2 = q.rx_s1;
    d.rx_prev = q.rx_s2;
    // bus: address phase captured, write done in the data phase
    d.wr_pend = accept && hwrite;
    if (accept) begin
      d.wr_addr = haddr[7:0];
    end
    if (accept && !hwrite) begin
      d.rdata = read_word(q, haddr[7:0], tx_sum.sum, rx_sum.sum);
    end
    if (hit(q.wr_pend, q.wr_addr, OFF_PARAM_TWO)) begin
      d.param_two_field = w[8:0];
    end
    if (hit(q.wr_pend, q.wr_addr, OFF_PARAM_THREE)) begin
      d.param_three_field = w;
    end
    if (hit(q.wr_pend, q.wr_addr, OFF_PARAM_THREE_HIGH)) begin
      d.param_three_high = w[7:0];
    end
    if (hit(q.wr_pend, q.wr_addr, OFF_SMARTCARD_CONFIG)) begin
      d.retransmit_count = w[RPT_LSB +: 2];
      d.logic_convention_sel = w[LOGIC_CONVENTION_SEL_BIT];
      d.error_pulldown_length = w[PULLDOWN_BIT];
      d.card_protocol_sel = w[PROTOCOL_BIT];
    end
    if (hit(q.wr_pend, q.wr_addr, OFF_SMARTCARD_IRQ)) begin
      d.rx_repeat_flag = w[RX_REPEAT_FLAG_BIT];
      d.tx_repeat_flag = w[TX_REPEAT_FLAG_BIT];
      d.block_time_flag = w[BLOCK_FLAG_BIT];
      d.wait_time_flag = w[WAIT_FLAG_BIT];
      d.guard_time_flag = w[GUARD_FLAG_BIT];
      d.rx_repeat_irq_en = w[RX_REPEAT_IE_BIT];
      d.tx_repeat_irq_en = w[TX_REPEAT_IE_BIT];
      d.block_time_irq_en = w[BLOCK_IE_BIT];
      d.wait_time_irq_en = w[WAIT_IE_BIT];
      d.guard_time_irq_en = w[GUARD_IE_BIT];
    end
    if (hit(q.wr_pend, q.wr_addr, OFF_WAKE_AUTOBAUD_IRQ)) begin
      d.wakeup_flag = w[WAKEUP_FLAG_BIT];
      d.autobaud_done_flag = w[AUTOBAUD_FLAG_BIT];
      d.autobaud_done_irq_en = w[AUTOBAUD_IE_BIT];
    end
    if (hit(q.wr_pend, q.wr_addr, OFF_PROTOCOL_CONTROL)) begin
      d.mode = w[MODE_LSB +: 3];
      d.checksum_include_ctrl = w[CHECKSUM_INCLUDE_BIT];
      d.wake_en = w[WAKE_ENABLE_BIT];
      d.autobaud_enable = w[AUTOBAUD_ENABLE_BIT];
    end
    // guard, block and waiting counters; hardware sets win over clears
    d.guard_cnt = guard_r[8:0];
    d.block_cnt = block_r[8:0];
    d.wait_cnt = wait_r[23:0];
    if (guard_r[24]) begin
      d.guard_run = 1'b0;
      d.guard_time_flag = 1'b1;
    end
    if (block_r[24]) begin
      d.block_run = 1'b0;
      d.block_time_flag = 1'b1;
    end
    if (wait_r[24]) begin
      d.wait_run = 1'b0;
      d.wait_time_flag = 1'b1;
    end
    if (card_mode && guard_start) begin
      d.guard_cnt = guard_load_value;
      d.guard_run = 1'b1;
    end
    if (card_mode && block_start) begin
      d.block_cnt = q.param_two_field;
      d.block_run = 1'b1;
    end
    if (card_mode && wait_start) begin
      d.wait_cnt = {q.param_three_high, q.param_three_field};
      d.wait_run = 1'b1;
    end
    if (!card_mode) begin
      d.guard_run = 1'b0;
      d.block_run = 1'b0;
      d.wait_run = 1'b0;
    end
    // T=0 character repetition
    if (card_mode && !q.card_protocol_sel) begin
      if (tx_line_err) begin
        if (q.tx_errs == ({1'b0, q.retransmit_count} + 3'h1)) begin
          d.tx_errs = 3'h0;
          d.tx_repeat_flag = 1'b1;
        end else begin
          d.tx_errs = q.tx_errs + 3'h1;
          d.retransmit = 1'b1;
        end
      end else if (tx_char_ok) begin
        d.tx_errs = 3'h0;
      end
      if (rx_parity_err) begin
        d.pulldown_cnt = q.error_pulldown_length ? PULLDOWN_TWO_ETU : PULLDOWN_ONE_ETU;
        if (q.rx_errs == RX_LAST_ERROR) begin
          d.rx_errs = 3'h0;
          d.rx_repeat_flag = 1'b1;
        end else begin
          d.rx_errs = q.rx_errs + 3'h1;
        end
      end else if (rx_char_ok) begin
        d.rx_errs = 3'h0;
      end
    end else begin
      d.tx_errs = 3'h0;
      d.rx_errs = 3'h0;
    end
    if (!rx_parity_err && etu_tick && q.pulldown_cnt != 2'h0) begin
      d.pulldown_cnt = q.pulldown_cnt - 2'h1;
    end
    if (!card_mode) begin
      d.pulldown_cnt = 2'h0;
    end
    // wake-up on a falling receive edge
    if (q.wake_en && falling) begin
      d.wakeup_flag = 1'b1;
    end
    // auto-baud: completes on the fifth falling edge, then disarms itself
    if (!q.autobaud_enable) begin
      d.autobaud_falls = 3'h0;
    end else if (falling) begin
      if (q.autobaud_falls + 3'h1 == AUTOBAUD_FALLS) begin
        d.autobaud_falls = 3'h0;
        d.autobaud_done_flag = 1'b1;
        d.autobaud_enable = 1'b0;
      end else begin
        d.autobaud_falls = q.autobaud_falls + 3'h1;
      end
    end
    // interrupt outputs
    d.card_irq = (d.rx_repeat_flag && d.rx_repeat_irq_en) ||
                 (d.tx_repeat_flag && d.tx_repeat_irq_en) ||
                 (d.block_time_flag && d.block_time_irq_en) ||
                 (d.wait_time_flag && d.wait_time_irq_en) ||
                 (d.guard_time_flag && d.guard_time_irq_en);
    d.event_irq = d.wakeup_flag ||
                  (d.autobaud_done_flag && d.autobaud_done_irq_en);
    d.line_oe_n = (d.pulldown_cnt == 2'h0);
  end
  // =====================================================================
  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.bus_ready <= 1'b1;
      q.line_oe_n <= 1'b1;
    end else begin
      q <= d;
    end
  end
  // =====================================================================
  // outputs
  assign hrdata = q.rdata;
  assign hreadyout = q.bus_ready;
  assign hresp = q.resp;
  assign retransmit_req = q.retransmit;
  assign logic_convention_sel = q.logic_convention_sel;
  assign card_protocol_sel = q.card_protocol_sel;
  assign error_line_o = q.line_o;
  assign error_line_oe_n = q.line_oe_n;
  assign card_irq = q.card_irq;
  assign event_irq = q.event_irq;
endmodule

// >>> uart_proto_pkg.sv
// constants shared by the protocol support register group
package uart_proto_pkg;

  // =====================================================================
  // register map (byte addresses)
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_PARAM_TWO = 8'h00;
  localparam logic [7:0] OFF_PARAM_THREE = 8'h04;
  localparam logic [7:0] OFF_PARAM_THREE_HIGH = 8'h08;
  localparam logic [7:0] OFF_TX_CHECKSUM = 8'h0C;
  localparam logic [7:0] OFF_RX_CHECKSUM = 8'h10;
  localparam logic [7:0] OFF_SMARTCARD_CONFIG = 8'h14;
  localparam logic [7:0] OFF_SMARTCARD_IRQ = 8'h18;
  localparam logic [7:0] OFF_WAKE_AUTOBAUD_IRQ = 8'h1C;
  localparam logic [7:0] OFF_PROTOCOL_CONTROL = 8'h20;

  // =====================================================================
  // field positions
  localparam int RPT_LSB = 4;
  localparam int LOGIC_CONVENTION_SEL_BIT = 3;
  localparam int PULLDOWN_BIT = 2;
  localparam int PROTOCOL_BIT = 1;
  localparam int RX_REPEAT_FLAG_BIT = 13;
  localparam int TX_REPEAT_FLAG_BIT = 12;
  localparam int BLOCK_FLAG_BIT = 10;
  localparam int WAIT_FLAG_BIT = 9;
  localparam int GUARD_FLAG_BIT = 8;
  localparam int RX_REPEAT_IE_BIT = 5;
  localparam int TX_REPEAT_IE_BIT = 4;
  localparam int BLOCK_IE_BIT = 2;
  localparam int WAIT_IE_BIT = 1;
  localparam int GUARD_IE_BIT = 0;
  localparam int WAKEUP_FLAG_BIT = 7;
  localparam int AUTOBAUD_FLAG_BIT = 6;
  localparam int AUTOBAUD_IE_BIT = 2;
  localparam int MODE_LSB = 0;
  localparam int CHECKSUM_INCLUDE_BIT = 4;
  localparam int WAKE_ENABLE_BIT = 5;
  localparam int AUTOBAUD_ENABLE_BIT = 6;

  // =====================================================================
  // reset values
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [7:0] RESET_SUM = 8'h00;

  // =====================================================================
  // protocol modes held in the control register
  localparam logic [2:0] MODE_ASYNC = 3'h0;
  localparam logic [2:0] MODE_LIN_MASTER = 3'h1;
  localparam logic [2:0] MODE_LIN_SLAVE = 3'h2;
  localparam logic [2:0] MODE_LIN_MASTER_SLAVE = 3'h3;
  localparam logic [2:0] MODE_DMX = 3'h4;
  localparam logic [2:0] MODE_SMARTCARD = 3'h5;

  // =====================================================================
  // counts
  localparam logic [2:0] RX_LAST_ERROR = 3'h4;
  localparam logic [2:0] AUTOBAUD_FALLS = 3'h5;
  localparam logic [1:0] PULLDOWN_ONE_ETU = 2'h1;
  localparam logic [1:0] PULLDOWN_TWO_ETU = 2'h2;

endpackage

// >>> sum_if.sv
// link between the register group and one checksum accumulator
`timescale 1ns/1ps
interface sum_if;
  logic add_valid;
  logic [7:0] add_byte;
  logic clear;
  logic load;
  logic [7:0] load_value;
  logic [7:0] sum;

  modport acc (
    input add_valid,
    input add_byte,
    input clear,
    input load,
    input load_value,
    output sum
  );

  modport feed (
    output add_valid,
    output add_byte,
    output clear,
    output load,
    output load_value,
    input sum
  );
endinterface

// >>> checksum_acc.sv
// eight-bit checksum accumulator with end-around carry
`timescale 1ns/1ps
module checksum_acc (
  input wire logic hclk,
  input wire logic hresetn,
  sum_if.acc port
);
  import uart_proto_pkg::*;

  typedef struct packed {
    logic [7:0] sum;
  } acc_s;

  acc_s q;
  acc_s d;
  logic [8:0] raw;

  // =====================================================================
  // next state
  always_comb begin
    d = q;
    raw = {1'b0, q.sum} + {1'b0, port.add_byte};
    if (port.clear) begin
      d.sum = RESET_SUM;
    end else if (port.load) begin
      d.sum = port.load_value;
    end else if (port.add_valid) begin
      d.sum = raw[7:0] + {7'h00, raw[8]};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign port.sum = q.sum;
endmodule

// >>> proto_support_regs_checker.sv
// port assertions for the protocol support register group
`timescale 1ns/1ps
module proto_support_regs_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic tx_line_err,
  input wire logic rx_parity_err,
  input wire logic retransmit_req,
  input wire logic logic_convention_sel,
  input wire logic card_protocol_sel,
  input wire logic error_line_o,
  input wire logic error_line_oe_n
);
  logic wr_dp_q;
  // =====================================================================
  // write data phase marker
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_dp_q <= 1'b0;
    end else begin
      wr_dp_q <= hsel & htrans[1] & hready & hwrite;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // =====================================================================
  // assertions
  property p_rt_cause; retransmit_req |-> $past(tx_line_err); endproperty
  a_rt_cause: assert property (p_rt_cause) else $error("retransmit without error");
  property p_rt_pulse; retransmit_req |=> !retransmit_req; endproperty
  a_rt_pulse: assert property (p_rt_pulse) else $error("retransmit too long");
  property p_rt_t0; retransmit_req |-> !card_protocol_sel; endproperty
  a_rt_t0: assert property (p_rt_t0) else $error("retransmit in block protocol");
  property p_pd_cause; $fell(error_line_oe_n) |-> $past(rx_parity_err); endproperty
  a_pd_cause: assert property (p_pd_cause) else $error("pull-down without cause");
  property p_pd_low; !error_line_oe_n |-> !error_line_o; endproperty
  a_pd_low: assert property (p_pd_low) else $error("pull-down drives high");
  property p_pd_end; $fell(error_line_oe_n) |-> ##[1:24] error_line_oe_n; endproperty
  a_pd_end: assert property (p_pd_end) else $error("pull-down never ends");
  property p_logic_convention_sel; $changed(logic_convention_sel) |-> $past(wr_dp_q); endproperty
  a_logic_convention_sel: assert property (p_logic_convention_sel) else $error("convention moved alone");
  property p_prot; $changed(card_protocol_sel) |-> $past(wr_dp_q); endproperty
  a_prot: assert property (p_prot) else $error("protocol moved alone");
  property p_bus; hreadyout && !hresp; endproperty
  a_bus: assert property (p_bus) else $error("bus answer not ready or okay");
endmodule
bind proto_support_regs proto_support_regs_checker proto_support_regs_checker_i (.hclk,
  .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp, .tx_line_err,
  .rx_parity_err, .retransmit_req, .logic_convention_sel, .card_protocol_sel, .error_line_o,
  .error_line_oe_n);

// >>> card_peer.sv
// serial line peer: bit clock ticks and receive line falls
`timescale 1ns/1ps
module card_peer #(
  parameter int ETU_CYC = 10
) (
  input wire logic hclk,
  input wire logic hresetn,
  output logic rx_pin,
  output logic etu_tick
);
  int div = 0;
  initial begin
    rx_pin = 1'b1;
    etu_tick = 1'b0;
  end
  // one tick per elementary time unit
  always @(posedge hclk) begin
    div <= (!hresetn || div == ETU_CYC - 1) ? 0 : div + 1;
    etu_tick <= hresetn && (div == ETU_CYC - 1);
  end
  // idle line rests high; each fall drives it low for four clocks, then high for four
  task automatic fall(input int n);
    repeat (n) begin
      @(posedge hclk);
      rx_pin <= 1'b0;
      repeat (4) @(posedge hclk);
      rx_pin <= 1'b1;
      repeat (4) @(posedge hclk);
    end
  endtask
endmodule

// >>> proto_support_regs_tb_top.sv
// self-checking bench for the protocol support register group
`timescale 1ns/1ps
module proto_support_regs_tb_top;
  import uart_proto_pkg::*;
  localparam logic [9:0] SUM = 10'h300, BRK = 10'h080, TOK = 10'h040, TERR = 10'h020,
    ROK = 10'h010, PERR = 10'h008;
  logic hclk, hresetn, hsel, hwrite, pid, hreadyout, hresp, rx_pin, etu_tick;
  logic retransmit_req, logic_convention_sel, card_protocol_sel, error_line_o;
  logic error_line_oe_n, card_irq, event_irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] byte_q;
  logic [9:0] ev;
  logic [8:0] guard_load_value;
  int n_fail, n_checks, b, d;
  int cyc = 0;
  int n_rt = 0;
  int n_low = 0;
  logic [7:0] r_a [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h24};
  logic [31:0] r_w [9] = '{32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h1A5, 32'h15A,
    32'hFFFF, 32'h37, 32'h4, 32'hFFFF_FFFF};
  logic [31:0] r_e [9] = '{32'h1FF, 32'hFFFF, 32'hFF, 32'hA5, 32'h5A, 32'h3E, 32'h37, 32'h4,
    32'h0};
  proto_support_regs proto_support_regs_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .rx_pin,
    .etu_tick, .tx_byte_valid(ev[9]), .tx_byte(byte_q), .tx_is_pid(pid),
    .rx_byte_valid(ev[8]), .rx_byte(byte_q), .rx_is_pid(pid), .break_detected(ev[7]),
    .tx_char_ok(ev[6]), .tx_line_err(ev[5]), .rx_char_ok(ev[4]), .rx_parity_err(ev[3]),
    .guard_load_value, .guard_start(ev[2]), .block_start(ev[1]), .wait_start(ev[0]),
    .retransmit_req, .logic_convention_sel, .card_protocol_sel, .error_line_o,
    .error_line_oe_n, .card_irq, .event_irq);
  card_peer #(.ETU_CYC(10)) card_peer_i (.hclk, .hresetn, .rx_pin, .etu_tick);
  // =====================================================================
  // clock, monitors, timeout
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    n_rt <= n_rt + (retransmit_req === 1'b1);
    n_low <= n_low + (error_line_oe_n === 1'b0);
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      give_verdict();
    end
  end
  // =====================================================================
  // tasks
  task automatic give_verdict();
    if (n_fail == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    @(posedge hclk iff hreadyout);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk iff hreadyout);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    bus(1'b1, a, wd);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(nm, e, rd);
  endtask
  task automatic pulse(input logic [9:0] m, input logic [7:0] v, input logic p);
    @(posedge hclk);
    ev <= m;
    byte_q <= v;
    pid <= p;
    @(posedge hclk);
    ev <= '0;
  endtask
  task automatic sums(input logic [7:0] e);
    rdc("tx sum", 8'h0C, {24'h0, e});
    rdc("rx sum", 8'h10, {24'h0, e});
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge hclk iff etu_tick);
  endtask
  task automatic quiet();
    wr(8'h20, 32'h0);
    wr(8'h18, 32'h0);
    wr(8'h20, 32'h5);
  endtask
  // =====================================================================
  // main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h0;
    ev = '0;
    byte_q = 8'h00;
    pid = 1'b0;
    guard_load_value = 9'h003;
    n_fail = 0;
    n_checks = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    check("idle outputs", 32'h4, {retransmit_req, logic_convention_sel, card_protocol_sel,
      error_line_oe_n, card_irq, event_irq});
    foreach (r_a[i]) rdc("reset value", r_a[i], 32'h0);
    foreach (r_a[i]) begin
      wr(r_a[i], r_w[i]);
      rdc("register", r_a[i], r_e[i]);
    end
    repeat (2) @(posedge hclk);
    check("convention", 32'h1, logic_convention_sel);
    check("protocol", 32'h1, card_protocol_sel);
    wr(8'h20, 32'h11);
    wr(8'h0C, 32'h0);
    wr(8'h10, 32'h0);
    pulse(SUM, 8'hF0, 1'b1);
    pulse(SUM, 8'h20, 1'b0);
    pulse(SUM, 8'h30, 1'b0);
    sums(8'h41);
    wr(8'h20, 32'h01);
    pulse(SUM, 8'hF0, 1'b1);
    pulse(SUM, 8'hC0, 1'b0);
    sums(8'h02);
    wr(8'h20, 32'h00);
    pulse(SUM, 8'h77, 1'b0);
    sums(8'h02);
    wr(8'h20, 32'h10);
    pulse(SUM, 8'h80, 1'b0);
    sums(8'h82);
    wr(8'h20, 32'h11);
    pulse(BRK, 8'h00, 1'b0);
    sums(8'h82);
    wr(8'h20, 32'h12);
    pulse(BRK, 8'h00, 1'b0);
    sums(8'h00);
    wr(8'h20, 32'h13);
    pulse(SUM, 8'h09, 1'b0);
    pulse(BRK, 8'h00, 1'b0);
    sums(8'h00);
    wr(8'h20, 32'h05);
    for (int r = 0; r < 4; r++) begin
      wr(8'h14, r << 4);
      wr(8'h18, 32'h0);
      pulse(TOK, 8'h00, 1'b0);
      b = n_rt;
      repeat (r + 2) pulse(TERR, 8'h00, 1'b0);
      repeat (2) @(posedge hclk);
      check("retransmits", r + 1, n_rt - b);
      rdc("tx repeat flag", 8'h18, 32'h1000);
    end
    wr(8'h14, 32'h2);
    wr(8'h18, 32'h0);
    b = n_rt;
    pulse(TERR, 8'h00, 1'b0);
    rdc("block protocol flags", 8'h18, 32'h0);
    check("block protocol retransmits", 32'h0, n_rt - b);
    wr(8'h14, 32'h0);
    pulse(ROK, 8'h00, 1'b0);
    check("direct convention", 32'h0, logic_convention_sel);
    for (int i = 1; i <= 5; i++) begin
      wr(8'h14, (i == 1) ? 32'h4 : 32'h0);
      b = n_low;
      pulse(PERR, 8'h00, 1'b0);
      repeat (25) @(posedge hclk);
      d = n_low - b;
      check("pull-down span", 32'h1, (i == 1) ? (d >= 11 && d <= 21) : (d >= 1 && d <= 10));
      if (i == 4) rdc("rx repeat early", 8'h18, 32'h0);
    end
    rdc("rx repeat flag", 8'h18, 32'h2000);
    wr(8'h00, 32'h3);
    wr(8'h04, 32'h3);
    wr(8'h08, 32'h0);
    quiet();
    wr(8'h18, 32'h6);
    pulse(10'h007, 8'h00, 1'b0);
    ticks(1);
    rdc("counter flags early", 8'h18, 32'h6);
    ticks(3);
    rdc("counter flags", 8'h18, 32'h706);
    check("card irq", 32'h1, card_irq);
    quiet();
    guard_load_value <= 9'h005;
    pulse(10'h004, 8'h00, 1'b0);
    ticks(4);
    rdc("guard flag early", 8'h18, 32'h0);
    ticks(1);
    rdc("guard flag", 8'h18, 32'h100);
    check("card irq masked", 32'h0, card_irq);
    wr(8'h18, 32'h101);
    repeat (3) @(posedge hclk);
    check("card irq enabled", 32'h1, card_irq);
    wr(8'h04, 32'h0);
    wr(8'h08, 32'h1);
    quiet();
    pulse(10'h001, 8'h00, 1'b0);
    ticks(4);
    rdc("wide wait counter", 8'h18, 32'h0);
    wr(8'h20, 32'h20);
    wr(8'h1C, 32'h0);
    card_peer_i.fall(1);
    rdc("wake flag", 8'h1C, 32'h80);
    check("wake event", 32'h1, event_irq);
    wr(8'h1C, 32'h0);
    wr(8'h20, 32'h0);
    card_peer_i.fall(1);
    rdc("wake disabled", 8'h1C, 32'h0);
    wr(8'h20, 32'h40);
    card_peer_i.fall(4);
    rdc("autobaud early", 8'h1C, 32'h0);
    card_peer_i.fall(1);
    rdc("autobaud flag", 8'h1C, 32'h40);
    check("autobaud masked", 32'h0, event_irq);
    rdc("autobaud enable", 8'h20, 32'h0);
    wr(8'h1C, 32'h44);
    repeat (3) @(posedge hclk);
    check("autobaud event", 32'h1, event_irq);
    give_verdict();
  end
endmodule
